/* File: hw/eeprom_bus_consts.svh */
// constants for the two-wire serial memory front end
`ifndef EEPROM_BUS_CONSTS_SVH
`define EEPROM_BUS_CONSTS_SVH
// clock rate in MHz
`define CLK_MHZ 100
// first command delay, 10.0 ms, held in us
`define FIRST_CMD_DELAY_US 10000
// least delay in cycles, rounded up
`define FIRST_CMD_CYCLES (`FIRST_CMD_DELAY_US * `CLK_MHZ)
// spike suppression window in ns
`define GLITCH_NS 50
// glitch window in cycles, rounded down, not clamped to one
`define GLITCH_CYCLES ((`GLITCH_NS * `CLK_MHZ) / 1000)
// device address byte fields
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define DEV_SEL_MSB 3
`define DEV_SEL_LSB 1
`define DEV_RW_BIT 0
`define TYPE_MEM 4'hA
`define TYPE_SEC 4'hB
// word address fields
`define ARRAY_ADDR_MSB 11
`define SEC_FUNC_MSB 10
`define SEC_FUNC_LSB 9
`define IDPAGE_IDX_MSB 4
`define UID_IDX_MSB 3
// secondary function codes in word bits 10:9
`define SEC_IDPAGE 2'h0
`define SEC_UID 2'h1
`define SEC_LOCK 2'h2
`define SEC_SWP 2'h3
// bit counts within one byte frame
`define LAST_DATA_BIT 4'h7
`define ACK_SLOT 4'h8
`endif

/* File: hw/eeprom_bus_pkg.sv */
// types shared by the serial memory bus front end
package eeprom_bus_pkg;
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_WHI  = 3'h2,
    ST_WLO  = 3'h3,
    ST_DATA = 3'h4,
    ST_READ = 3'h5
  } state_t;
  // decoded target of a command
  typedef enum logic [2:0] {
    FN_NONE   = 3'h0,
    FN_ARRAY  = 3'h1,
    FN_IDPAGE = 3'h2,
    FN_UID    = 3'h3,
    FN_LOCK   = 3'h4,
    FN_SWP    = 3'h5
  } func_t;
  // decoded command after both word bytes, rw after the address byte
  typedef struct packed {
    func_t       func;
    logic        rw;
    logic [15:0] wordAddr;
    logic [11:0] index;
  } cmd_t;
  // one accepted write data byte
  typedef struct packed {
    logic       valid;
    func_t      func;
    logic [7:0] data;
  } wrbyte_t;
endpackage

/* File: hw/serial_eeprom_bus_front_end.sv */
// two-wire slave front end: conditions, bytes, ack, address decode
// Behaviour
// - sample on scl rise, drive after fall
// - msb first, eight bits plus ack slot
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - stop after write launches write cycle
// - ack holds sda low whole ninth clock
// - standby after powerup, stop, operation done
// - start, nine clocks, start, stop recovers
// - silent during power reset, then standby
// - write protect pin blocks writes
// - soft protect bit blocks array and id page writes
// - address byte: type, select, rw fields
// - type 1011 selects secondary functions
// - select bits must match select pins
// - rw one reads, zero writes
// - ack match, nack mismatch then standby
// - two word bytes, high first, acked
// - array uses word bits 11 to 0
// - secondary decode from word bits 10:9
// - lock reached only with rw zero
// - unique id needs rw one, never reached as reads skip word bytes
// - protect pin nacks write data bytes
`include "eeprom_bus_consts.svh"
module serial_eeprom_bus_front_end #(
  parameter int FIRST_CMD_CYCLES = `FIRST_CMD_CYCLES,
  parameter int GLITCH_CYCLES    = `GLITCH_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   sclClk,
  input  wire logic                   sdaIn,
  output logic                        sdaOut,
  output logic                        sdaOeN,
  input  wire logic [2:0]             chipSelectIn,
  input  wire logic                   wpIn,
  input  wire logic                   porActive,
  input  wire logic                   softWriteProtectBit,
  input  wire logic                   idPageLocked,
  input  wire logic                   opBusy,
  output eeprom_bus_pkg::cmd_t        cmd,
  output eeprom_bus_pkg::wrbyte_t     wrData,
  output logic                        writeCycleStart,
  output logic                        standby,
  output logic                        initReady
);

  localparam int FW = $clog2(GLITCH_CYCLES + 1);

  // link domain: bit taken on each scl rise
  logic        linkBit_q;   // last sampled data bit
  // pin synchronisers and filters
  logic [1:0]  rawLine;     // {scl, sda} raw pins
  logic [1:0]  lineA_q;     // first sync stage
  logic [1:0]  lineB_q;     // second sync stage
  logic [1:0]  lineF_q;     // filtered levels
  logic [1:0]  lineP_q;     // filtered, one cycle late
  logic [3:0]  pinA_q;      // {wp, select} first stage
  logic [3:0]  pinB_q;      // {wp, select} second stage
  // decoded bus events
  logic        sclRise;     // filtered scl rising
  logic        sclFall;     // filtered scl falling
  logic        startDet;    // start condition seen
  logic        stopDet;     // stop condition seen
  logic        wpS;         // synced protect pin
  logic [2:0]  csS;         // synced select pins
  // protocol state
  eeprom_bus_pkg::state_t state_q;
  logic [3:0]  bitCnt_q;    // bits of the current frame
  logic [6:0]  shift_q;     // bits received so far
  logic [7:0]  byteNow;     // byte completed by this bit
  logic        ackNow_q;    // ack chosen for this frame
  logic        secQ_q;      // secondary type selected
  logic        rwQ_q;       // rw bit of address byte
  logic [7:0]  addrHi_q;    // first word address byte
  logic        wrPending_q; // acked data awaiting stop
  logic        prot;        // writes blocked
  logic        dataOk;      // data byte may be acked
  logic [19:0] initCnt_q;   // power-up wait counter
  eeprom_bus_pkg::func_t funcNow;

  // link clock samples sda on scl rise
  always_ff @(posedge sclClk) begin
    linkBit_q <= sdaIn;
  end

  assign rawLine = {sclClk, sdaIn};

  // per line: two flops, then a stability filter
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [FW-1:0] cnt_q; // cycles the new level has held
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        lineA_q[i] <= 1'b1;
        lineB_q[i] <= 1'b1;
        lineF_q[i] <= 1'b1;
        lineP_q[i] <= 1'b1;
        cnt_q      <= '0;
      end else if (ce) begin
        lineA_q[i] <= rawLine[i];
        lineB_q[i] <= lineA_q[i];
        lineP_q[i] <= lineF_q[i];
        // level must hold the whole window to pass
        if (lineB_q[i] == lineF_q[i]) begin
          cnt_q <= '0;
        end else if (cnt_q == FW'(GLITCH_CYCLES - 1)) begin
          lineF_q[i] <= lineB_q[i];
          cnt_q      <= '0;
        end else begin
          cnt_q <= cnt_q + FW'(1);
        end
      end
    end
  end

  // static pins also cross through two flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinA_q <= 4'h0;
      pinB_q <= 4'h0;
    end else if (ce) begin
      pinA_q <= {wpIn, chipSelectIn};
      pinB_q <= pinA_q;
    end
  end

  assign wpS = pinB_q[3];
  assign csS = pinB_q[2:0];

  // edges and bus conditions from filtered levels
  assign sclRise  = lineF_q[1] & ~lineP_q[1];
  assign sclFall  = ~lineF_q[1] & lineP_q[1];
  assign startDet = lineF_q[1] & lineP_q[1] & lineP_q[0] & ~lineF_q[0];
  assign stopDet  = lineF_q[1] & lineP_q[1] & ~lineP_q[0] & lineF_q[0];

  // bit from link domain, stable until the next scl rise
  assign byteNow = {shift_q, linkBit_q};

  // secondary function decode from word bits 10:9
  always_comb begin
    funcNow = eeprom_bus_pkg::FN_ARRAY;
    if (secQ_q) begin
      case (addrHi_q[`SEC_FUNC_MSB-8:`SEC_FUNC_LSB-8])
        `SEC_IDPAGE: funcNow = eeprom_bus_pkg::FN_IDPAGE;
        `SEC_UID: funcNow = rwQ_q ? eeprom_bus_pkg::FN_UID
                                  : eeprom_bus_pkg::FN_NONE;
        `SEC_LOCK: funcNow = rwQ_q ? eeprom_bus_pkg::FN_NONE
                                   : eeprom_bus_pkg::FN_LOCK;
        `SEC_SWP: funcNow = eeprom_bus_pkg::FN_SWP;
        default: funcNow = eeprom_bus_pkg::FN_NONE;
      endcase
    end
  end

  // write permission of a data byte
  assign prot = wpS | softWriteProtectBit;
  always_comb begin
    case (cmd.func)
      eeprom_bus_pkg::FN_ARRAY: dataOk = ~prot;
      eeprom_bus_pkg::FN_IDPAGE: dataOk = ~prot & ~idPageLocked;
      eeprom_bus_pkg::FN_LOCK: dataOk = ~wpS & ~idPageLocked;
      eeprom_bus_pkg::FN_SWP: dataOk = ~wpS;
      default: dataOk = 1'b0;
    endcase
  end

  // protocol sequencer: frames, bit count, ack choice
  always_ff @(posedge clk) begin
    if (!rst_n || porActive) begin
      state_q         <= eeprom_bus_pkg::ST_IDLE;
      bitCnt_q        <= 4'h0;
      shift_q         <= 7'h00;
      ackNow_q        <= 1'b0;
      secQ_q          <= 1'b0;
      rwQ_q           <= 1'b0;
      addrHi_q        <= 8'h00;
      wrPending_q     <= 1'b0;
      writeCycleStart <= 1'b0;
      wrData          <= '0;
    end else if (ce) begin
      writeCycleStart <= 1'b0;
      wrData.valid    <= 1'b0;
      if (startDet) begin
        // any start, even mid byte, opens a new address byte
        state_q     <= eeprom_bus_pkg::ST_DEV;
        bitCnt_q    <= 4'h0;
        ackNow_q    <= 1'b0;
        wrPending_q <= 1'b0;
      end else if (stopDet) begin
        // stop in the clock after a data ack starts the write
        writeCycleStart <= wrPending_q & (bitCnt_q <= 4'h1);
        state_q         <= eeprom_bus_pkg::ST_IDLE;
        bitCnt_q        <= 4'h0;
        ackNow_q        <= 1'b0;
        wrPending_q     <= 1'b0;
      end else if (sclRise && state_q != eeprom_bus_pkg::ST_IDLE) begin
        shift_q  <= byteNow[6:0];
        bitCnt_q <= (bitCnt_q == `ACK_SLOT) ? 4'h0 : bitCnt_q + 4'h1;
        // a second bit past the ack means the stop came too late
        if (bitCnt_q == 4'h1) begin
          wrPending_q <= 1'b0;
        end
        if (bitCnt_q == `LAST_DATA_BIT) begin
          case (state_q)
            eeprom_bus_pkg::ST_DEV: begin
              if ((byteNow[7:4] == `TYPE_MEM || byteNow[7:4] == `TYPE_SEC)
                  && byteNow[`DEV_SEL_MSB:`DEV_SEL_LSB] == csS && !opBusy) begin
                ackNow_q <= 1'b1;
                secQ_q   <= byteNow[`DEV_TYPE_LSB];
                rwQ_q    <= byteNow[`DEV_RW_BIT];
                // read skips the word address bytes
                state_q  <= byteNow[`DEV_RW_BIT] ? eeprom_bus_pkg::ST_READ
                                                 : eeprom_bus_pkg::ST_WHI;
              end else begin
                ackNow_q <= 1'b0;
                state_q  <= eeprom_bus_pkg::ST_IDLE;
              end
            end
            eeprom_bus_pkg::ST_WHI: begin
              addrHi_q <= byteNow;
              ackNow_q <= 1'b1;
              state_q  <= eeprom_bus_pkg::ST_WLO;
            end
            eeprom_bus_pkg::ST_WLO: begin
              ackNow_q <= 1'b1;
              state_q  <= eeprom_bus_pkg::ST_DATA;
            end
            eeprom_bus_pkg::ST_DATA: begin
              // blocked bytes are nacked and not passed on
              ackNow_q     <= dataOk;
              wrPending_q  <= dataOk;
              wrData.valid <= dataOk;
              wrData.func  <= cmd.func;
              wrData.data  <= byteNow;
            end
            default: begin
              ackNow_q <= 1'b0; // master acks read data
            end
          endcase
        end
      end
    end
  end

  // decoded command, latched as the second word byte ends; rw also as the address byte ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (ce && sclRise && bitCnt_q == `LAST_DATA_BIT) begin
      if (state_q == eeprom_bus_pkg::ST_WLO) begin
        cmd.func     <= funcNow;
        cmd.rw       <= rwQ_q;
        cmd.wordAddr <= {addrHi_q, byteNow};
        case (funcNow)
          eeprom_bus_pkg::FN_ARRAY: cmd.index <= {addrHi_q[3:0], byteNow};
          eeprom_bus_pkg::FN_IDPAGE: cmd.index <= {7'h00, byteNow[`IDPAGE_IDX_MSB:0]};
          eeprom_bus_pkg::FN_UID: cmd.index <= {8'h00, byteNow[`UID_IDX_MSB:0]};
          default: cmd.index <= 12'h000;
        endcase
      end else if (state_q == eeprom_bus_pkg::ST_DEV) begin
        cmd.rw <= byteNow[`DEV_RW_BIT];
      end
    end
  end

  // sda driver: pulls low only on a filtered scl fall, released on a fall, a start or a stop
  always_ff @(posedge clk) begin
    if (!rst_n || porActive) begin
      sdaOeN <= 1'b1;
      sdaOut <= 1'b0;
    end else if (ce) begin
      sdaOut <= 1'b0; // open drain, only ever pulls low
      if (startDet || stopDet) begin
        sdaOeN <= 1'b1;
      end else if (sclFall) begin
        // held low from this fall until the one after the ninth rise
        sdaOeN <= ~(bitCnt_q == `ACK_SLOT && ackNow_q);
      end
    end
  end

  // standby indication and power-up wait
  always_ff @(posedge clk) begin
    if (!rst_n || porActive) begin
      standby   <= 1'b1;
      initReady <= 1'b0;
      initCnt_q <= 20'h00000;
    end else if (ce) begin
      standby <= (state_q == eeprom_bus_pkg::ST_IDLE) & ~opBusy;
      if (initCnt_q >= 20'(FIRST_CMD_CYCLES - 1)) begin
        initReady <= 1'b1;
      end else begin
        initCnt_q <= initCnt_q + 20'h00001;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce || porActive);

  sequence s_ackBegin;
    sclFall && bitCnt_q == `ACK_SLOT && ackNow_q && !startDet && !stopDet;
  endsequence

  sequence s_lastBit;
    sclRise && bitCnt_q == `LAST_DATA_BIT && !startDet && !stopDet;
  endsequence

  a_drive_after_fall: assert property ($fell(sdaOeN) |-> $past(sclFall))
    else $error("sda driven without a preceding scl fall");
  a_ack_holds_low: assert property (s_ackBegin |=> !sdaOeN [*2])
    else $error("ack released too early");
  a_start_restarts: assert property (startDet |=> state_q == eeprom_bus_pkg::ST_DEV && bitCnt_q == 4'h0)
    else $error("start did not restart the address byte");
  a_stop_to_idle: assert property (stopDet |=> state_q == eeprom_bus_pkg::ST_IDLE && sdaOeN)
    else $error("stop did not end the transaction");
  a_write_launch: assert property (writeCycleStart |-> $past(stopDet) && $past(wrPending_q))
    else $error("write cycle started without stop after data");
  a_sel_mismatch: assert property (s_lastBit and (state_q == eeprom_bus_pkg::ST_DEV
      && byteNow[3:1] != csS) |=> !ackNow_q && state_q == eeprom_bus_pkg::ST_IDLE)
    else $error("address with wrong select bits acked");
  a_wp_nack: assert property (s_lastBit and (state_q == eeprom_bus_pkg::ST_DATA && wpS)
      |=> !ackNow_q && !wrData.valid)
    else $error("data byte acked under write protect pin");
  a_swp_nack: assert property (s_lastBit and (state_q == eeprom_bus_pkg::ST_DATA && softWriteProtectBit
      && cmd.func == eeprom_bus_pkg::FN_ARRAY) |=> !ackNow_q)
    else $error("array write acked with soft protect set");
  a_word_acked: assert property (s_lastBit and (state_q == eeprom_bus_pkg::ST_WHI)
      |=> ackNow_q && state_q == eeprom_bus_pkg::ST_WLO)
    else $error("first word address byte not acked");
  a_idle_standby: assert property (state_q == eeprom_bus_pkg::ST_IDLE && !opBusy |=> standby)
    else $error("standby not shown while idle");

endmodule

/* File: test/bus_master_model.sv */
// two-wire bus master model driving the serial clock and data lines
module bus_master_model #(
  parameter int HALF = 30
) (
  input  wire logic lclk,
  input  wire logic sdaWire,
  output logic      sclClk,
  output logic      sdaM
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines idle high, clock stands still outside frames
  initial begin
    sclClk = 1'b1;
    sdaM   = 1'b1;
  end
  // wait a number of link ticks
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // start: data falls while clock high, also usable as a repeated start
  task automatic start();
    sdaM <= 1'b1;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF / 2);
    sdaM <= 1'b0;
    tick(HALF);
    sclClk <= 1'b0;
    tick(HALF / 2);
  endtask
  // one bit: data set mid low phase, sampled mid high phase
  task automatic bitOut(input logic b, output logic s);
    sdaM <= b;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF / 2);
    s = sdaWire;
    tick(HALF / 2);
    sclClk <= 1'b0;
    tick(HALF / 2);
  endtask
  // byte msb first, then released line for the answer slot
  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(v[i], s);
    end
    bitOut(1'b1, ack);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sdaM <= 1'b0;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF);
    sdaM <= 1'b1;
    tick(HALF);
  endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the serial memory bus front end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SEL  = 3'h5; // hard-wired select level
  localparam logic [7:0] DATA = 8'h5A; // write data, bit 1 set
  logic clk, lclk, rst_n, ce, porActive, wpIn, softWriteProtectBit, idPageLocked, opBusy;
  logic [2:0]              chipSelectIn;
  logic                    sdaOut, sdaOeN, writeCycleStart, standby, initReady, sclClk, sdaM;
  eeprom_bus_pkg::cmd_t    cmd;
  eeprom_bus_pkg::wrbyte_t wrData;
  int                      errors, checks, wcs, wrs;
  logic [7:0]              wrLast;
  // open-drain wire with pull-up
  wire sdaWire = sdaM & (sdaOeN | sdaOut);
  // system clock and unrelated link tick
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #3 lclk = ~lclk;
  end
  serial_eeprom_bus_front_end #(.FIRST_CMD_CYCLES(50), .GLITCH_CYCLES(5)) DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclClk(sclClk), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .chipSelectIn(chipSelectIn), .wpIn(wpIn), .porActive(porActive),
    .softWriteProtectBit(softWriteProtectBit), .idPageLocked(idPageLocked), .opBusy(opBusy),
    .cmd(cmd), .wrData(wrData), .writeCycleStart(writeCycleStart), .standby(standby),
    .initReady(initReady)
  );
  bus_master_model master (.lclk(lclk), .sdaWire(sdaWire), .sclClk(sclClk), .sdaM(sdaM));
  // count pulses and keep last accepted data byte
  always @(posedge clk) begin
    if (writeCycleStart === 1'b1) wcs++;
    if (wrData.valid === 1'b1) begin
      wrs++;
      wrLast <= wrData.data;
    end
  end
  // compare and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // static side inputs, changed at falling edge
  task automatic setIn(input logic [4:0] v);
    @(negedge clk);
    {wpIn, softWriteProtectBit, idPageLocked, opBusy, porActive} = v;
  endtask
  // start, nb bytes (address, word high, word low, data), stop; answers per byte
  task automatic frame(input logic [7:0] dev, input logic [15:0] wa, input int nb, output logic [3:0] acks);
    logic a;
    acks = 4'hF;
    wcs  = 0;
    wrs  = 0;
    master.start();
    for (int i = 0; i < nb; i++) begin
      master.sendByte(i == 0 ? dev : i == 1 ? wa[15:8] : i == 2 ? wa[7:0] : DATA, a);
      acks[i] = a;
    end
    master.stop();
    repeat (20) @(negedge clk);
  endtask
  // main sequence
  initial begin
    int         n;
    logic [3:0] ak;
    logic       a;
    logic [2:0] fexp [4];
    rst_n = 1'b0;
    ce = 1'b1;
    chipSelectIn = SEL;
    {wpIn, softWriteProtectBit, idPageLocked, opBusy, porActive} = 5'h00;
    errors = 0;
    checks = 0;
    fexp = '{eeprom_bus_pkg::FN_IDPAGE, eeprom_bus_pkg::FN_NONE, eeprom_bus_pkg::FN_LOCK, eeprom_bus_pkg::FN_SWP};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check("sdaOeN", sdaOeN, 1'b1);
    check("initReady", initReady, 1'b0);
    n = 0;
    while (initReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      finish_test();
    end
    check("initDelay", n >= 48 && n <= 52, 1'b1);
    check("standbyUp", standby, 1'b1);
    // plain array write
    frame({4'hA, SEL, 1'b0}, 16'hF123, 4, ak);
    check("arrayAcks", ak, 4'h0);
    check("arrayFunc", cmd.func, eeprom_bus_pkg::FN_ARRAY);
    check("arrayIndex", cmd.index, 12'h123);
    check("wordAddr", cmd.wordAddr, 16'hF123);
    check("wrData", wrLast, DATA);
    check("wrCount", wrs, 1);
    check("launch", wcs, 1);
    check("standbyWr", standby, 1'b1);
    // every select value, only the wired one answers
    for (int s = 0; s < 8; s++) begin
      frame({4'hA, s[2:0], 1'b0}, 16'h0, 1, ak);
      check("selAck", ak[0], s[2:0] != SEL);
      check("selStandby", standby, 1'b1);
    end
    // type identifiers, only two answer; bare stop launches nothing
    for (int t = 8; t < 16; t++) begin
      frame({t[3:0], SEL, 1'b0}, 16'h0, 1, ak);
      check("typeAck", ak[0], !(t == 10 || t == 11));
      check("noLaunch", wcs, 0);
    end
    // pin and soft protection: addresses acked, data refused
    for (int p = 0; p < 2; p++) begin
      setIn(p == 0 ? 5'h10 : 5'h08);
      frame({4'hA, SEL, 1'b0}, 16'h0456, 4, ak);
      check("protAcks", ak, 4'h8);
      check("protWr", wrs, 0);
      check("protLaunch", wcs, 0);
    end
    // locked id page refuses data
    setIn(5'h04);
    frame({4'hB, SEL, 1'b0}, 16'h0013, 4, ak);
    check("lockedAcks", ak, 4'h8);
    check("idIndex", cmd.index, 12'h013);
    setIn(5'h00);
    // secondary function decode, unique id unreachable with write
    for (int c = 0; c < 4; c++) begin
      frame({4'hB, SEL, 1'b0}, {5'h1F, c[1:0], 9'h1EA}, 4, ak);
      check("secFunc", cmd.func, fexp[c]);
      check("secAcks", ak, c == 1 ? 4'h8 : 4'h0);
      check("secLaunch", wcs, c == 1 ? 0 : 1);
      if (c == 0) check("secIndex", cmd.index, 12'h00A);
    end
    // read select, stop returns to standby
    frame({4'hB, SEL, 1'b1}, 16'h0, 1, ak);
    check("readAck", ak[0], 1'b0);
    check("readRw", cmd.rw, 1'b1);
    check("readLaunch", wcs, 0);
    check("readStandby", standby, 1'b1);
    // busy operation and power reset both refuse the address
    for (int p = 0; p < 2; p++) begin
      setIn(p == 0 ? 5'h02 : 5'h01);
      frame({4'hA, SEL, 1'b0}, 16'h0, 1, ak);
      check("busyNack", ak[0], 1'b1);
      if (p == 0) check("busyStandby", standby, 1'b0);
      setIn(5'h00);
      repeat (20) @(negedge clk);
      check("doneStandby", standby, 1'b1);
    end
    // start in mid byte restarts the address byte
    master.start();
    for (int i = 0; i < 4; i++) master.bitOut(1'b1, a);
    frame({4'hA, SEL, 1'b0}, 16'h0ABC, 4, ak);
    check("restartAcks", ak, 4'h0);
    check("restartIdx", cmd.index, 12'hABC);
    // bus recovery sequence
    master.start();
    for (int i = 0; i < 9; i++) master.bitOut(1'b1, a);
    master.start();
    master.stop();
    repeat (20) @(negedge clk);
    check("recStandby", standby, 1'b1);
    check("recRelease", sdaOeN, 1'b1);
    frame({4'hA, SEL, 1'b0}, 16'h0, 1, ak);
    check("recAck", ak[0], 1'b0);
    finish_test();
  end
endmodule
